// >>> kpms_pkg.sv
package kpms_pkg;
  // Matrix and direct-key geometry
  localparam int ROWS       = 8;
  localparam int COLS       = 6;
  localparam int DKEYS      = 8;
  localparam int ENC_W      = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DBNC   = 8'h04;
  localparam logic [7:0] OFS_ROWS   = 8'h08;
  localparam logic [7:0] OFS_DKEY   = 8'h0C;
  localparam logic [7:0] OFS_ENC    = 8'h10;
  localparam logic [7:0] OFS_STAT   = 8'h14;
  localparam logic [7:0] OFS_ICLR   = 8'h18;
  localparam logic [7:0] OFS_IEN    = 8'h1C;
  localparam logic [7:0] OFS_RES0   = 8'h20;

  // Control register fields
  localparam int CTL_COLSEL  = 0;
  localparam int CTL_MAT_EN  = 6;
  localparam int CTL_DIR_EN  = 7;
  localparam int CTL_IGNMULT = 8;
  localparam int CTL_AUTO_EN = 9;
  localparam int CTL_ACT_EN  = 10;
  localparam int CTL_ENCA_EN = 11;
  localparam int CTL_ENCB_EN = 12;
  localparam int CTL_START   = 13;
  localparam int CTL_W       = 13;

  // Status bits (sticky) and busy flag
  localparam int ST_MAT    = 0;
  localparam int ST_DIR    = 1;
  localparam int ST_SCAN   = 2;
  localparam int ST_W      = 3;
  localparam int ST_BUSY   = 8;

  // Reset values
  localparam logic [CTL_W-1:0] CTRL_RST = 13'h0000;
  localparam logic [7:0]       DBNC_RST = 8'h0A;

  // Timing: debounce tick and column settle time
  localparam int CLK_NS      = 8;
  localparam int TICK_NS     = 1000;
  localparam int SETTLE_NS   = 1000;
  localparam int TICK_CYC    = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC  = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    KPMS_IDLE,
    KPMS_DRIVE,
    KPMS_STORE
  } kpms_scan_t;
endpackage

// >>> kpms_quad.sv
module kpms_quad
  import kpms_pkg::*;
#(
  parameter int W = ENC_W
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rstn,
  // Synchronised sensor pair and enable
  input  wire logic         i_en,
  input  wire logic [1:0]   i_ph,
  // Step count
  output logic      [W-1:0] o_count
);

  logic [1:0]   prev_q;
  logic [W-1:0] cnt_q;

  // +1, -1 or 0 from a gray-code transition
  function automatic logic [1:0] kpms_step(input logic [1:0] p, input logic [1:0] c);
    case ({p, c})
      4'h1, 4'h7, 4'hE, 4'h8: kpms_step = 2'b01;
      4'h2, 4'hB, 4'hD, 4'h4: kpms_step = 2'b11;
      default:                kpms_step = 2'b00;
    endcase
  endfunction

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_q <= 2'h0;
    end else begin
      prev_q <= i_ph;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q <= '0;
    end else if (i_en) begin
      // Count only when enabled, so the pins are free for keys otherwise
      if (kpms_step(prev_q, i_ph) == 2'b01) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (kpms_step(prev_q, i_ph) == 2'b11) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign o_count = cnt_q;

  AST_ENC_IDLE: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !i_en |=> $stable(cnt_q))
    else $error("encoder count moved while disabled");
endmodule

// >>> kpms_top.sv
// Notes on behaviour
// - Handles 8x6 matrix, eight direct keys and two rotary encoders.
// - Matrix and direct keys are serviced together on separate paths.
// - A key press held stable longer than the debounce interval raises an interrupt.
// - Manual scan: software drives columns in turn and reads the rows.
// - Ignore-multiple policy gives one interrupt per press out of a released keypad.
// - Auto scan drives columns itself and stores each column's rows.
// - Scan-on-activity starts an auto scan; its completion interrupts.
// - Software-started auto scans complete without an interrupt.
// - Columns follow auto scan while busy, else the control select bits.
// - Row readings come from eight row inputs, one per row.
// - Shared direct and encoder inputs are used only when selected.
module kpms_top
  import kpms_pkg::*;
(
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rstn,
  // APB slave
  input  wire logic             i_psel,
  input  wire logic             i_penable,
  input  wire logic             i_pwrite,
  input  wire logic [7:0]       i_paddr,
  input  wire logic [31:0]      i_pwdata,
  output logic                  o_pready,
  output logic                  o_pslverr,
  output logic      [31:0]      o_prdata,
  // Keypad pins
  input  wire logic [ROWS-1:0]  i_matrix_row_in,
  input  wire logic [DKEYS-1:0] i_direct_key_in,
  output logic      [COLS-1:0]  o_column_scan_out,
  // Interrupt
  output logic                  o_irq
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [ROWS-1:0]  row_s1_q, row_s2_q;
  logic [DKEYS-1:0] dk_s1_q, dk_s2_q;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      row_s1_q <= '0;
      row_s2_q <= '0;
      dk_s1_q  <= '0;
      dk_s2_q  <= '0;
    end else begin
      row_s1_q <= i_matrix_row_in;
      row_s2_q <= row_s1_q;
      dk_s1_q  <= i_direct_key_in;
      dk_s2_q  <= dk_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [CTL_W-1:0] ctrl_q;
  logic [7:0]       dbnc_q;
  logic [ST_W-1:0]  stat_q, ien_q;
  logic [ROWS-1:0]  res_q [COLS];
  logic             start_q;
  logic             wr_en, setup;
  logic [31:0]      rdata_d;
  logic             hit_d;

  assign setup  = i_psel && !i_penable;
  assign wr_en  = i_psel && i_penable && i_pwrite;
  assign o_pready = 1'b1;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_q <= CTRL_RST;
      dbnc_q <= DBNC_RST;
      ien_q  <= '0;
    end else if (wr_en) begin
      if (i_paddr == OFS_CTRL) begin
        ctrl_q <= i_pwdata[CTL_W-1:0];
      end
      if (i_paddr == OFS_DBNC) begin
        dbnc_q <= i_pwdata[7:0];
      end
      if (i_paddr == OFS_IEN) begin
        ien_q <= i_pwdata[ST_W-1:0];
      end
    end
  end

  // Start is a self-clearing pulse; only honoured while auto scan is enabled
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      start_q <= 1'b0;
    end else begin
      start_q <= wr_en && (i_paddr == OFS_CTRL) && i_pwdata[CTL_START]
                 && i_pwdata[CTL_AUTO_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Encoders and direct keys
  logic [ENC_W-1:0] enc_cnt [2];
  logic [1:0]       enc_en;
  logic [DKEYS-1:0] dk_mask, dk_mon;

  assign enc_en = {ctrl_q[CTL_ENCB_EN], ctrl_q[CTL_ENCA_EN]};

  generate
    for (genvar e = 0; e < 2; e++) begin : g_enc
      kpms_quad #(.W(ENC_W)) u_quad (
        .i_mclk  (i_mclk),
        .i_rstn  (i_rstn),
        .i_en    (enc_en[e]),
        .i_ph    (dk_s2_q[2*e+1:2*e]),
        .o_count (enc_cnt[e])
      );
      assign dk_mask[2*e+1:2*e] = {2{!enc_en[e]}};
    end
  endgenerate
  assign dk_mask[DKEYS-1:4] = '1;

  // Pins claimed by an encoder or left unselected are not seen as keys
  assign dk_mon = ctrl_q[CTL_DIR_EN] ? (dk_s2_q & dk_mask) : '0;

  ////////////////////////////////////////////////////////////////////////
  // Debounce
  logic [ROWS-1:0]  mat_mon, mat_prev_q, mat_stb_q;
  logic [DKEYS-1:0] dk_prev_q, dk_stb_q, dk_out_q;
  logic [7:0]       tick_cnt_q;
  // One bit wider than the interval, so an interval of 8'hFF can still expire
  logic [8:0]       dbnc_cnt_q;
  logic             tick, changed, expired;
  logic             mat_evt, dir_evt, busy;

  // Hold the pattern while scanning: rows then show one column only, and a
  // key held across a scan must not come back as a new press
  assign mat_mon = busy ? mat_prev_q : (ctrl_q[CTL_MAT_EN] ? row_s2_q : '0);
  assign changed = (mat_mon != mat_prev_q) || (dk_mon != dk_prev_q);
  assign tick    = (tick_cnt_q == 8'(TICK_CYC - 1));
  assign expired = (dbnc_cnt_q > dbnc_q);

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      mat_prev_q <= '0;
      dk_prev_q  <= '0;
    end else begin
      mat_prev_q <= mat_mon;
      dk_prev_q  <= dk_mon;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_cnt_q <= '0;
    end else if (changed || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      dbnc_cnt_q <= '0;
    end else if (changed) begin
      dbnc_cnt_q <= '0;
    end else if (tick && !expired) begin
      dbnc_cnt_q <= dbnc_cnt_q + 1'b1;
    end
  end

  // New stable patterns with a key down become events; with the ignore policy only the
  // first press out of a released keypad counts
  assign mat_evt = expired && (mat_prev_q != mat_stb_q) && (|mat_prev_q)
                   && (!ctrl_q[CTL_IGNMULT] || !(|mat_stb_q));
  assign dir_evt = expired && (dk_prev_q != dk_stb_q) && (|dk_prev_q);

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      mat_stb_q <= '0;
      dk_stb_q  <= '0;
      dk_out_q  <= '0;
    end else if (expired) begin
      mat_stb_q <= mat_prev_q;
      dk_stb_q  <= dk_prev_q;
      dk_out_q  <= dk_prev_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Automatic scan
  kpms_scan_t       state_q;
  logic [2:0]       col_q;
  logic [7:0]       settle_q;
  logic             by_act_q, scan_done, act_start;

  assign act_start = mat_evt && ctrl_q[CTL_ACT_EN];
  assign busy      = (state_q != KPMS_IDLE);
  assign scan_done = (state_q == KPMS_STORE) && (col_q == 3'(COLS - 1));

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q  <= KPMS_IDLE;
      col_q    <= '0;
      settle_q <= '0;
      by_act_q <= 1'b0;
    end else begin
      case (state_q)
        KPMS_IDLE: begin
          if (act_start || start_q) begin
            state_q  <= KPMS_DRIVE;
            col_q    <= '0;
            settle_q <= '0;
            by_act_q <= act_start;
          end
        end
        KPMS_DRIVE: begin
          // Rows need time to follow the column before they are sampled
          if (settle_q == 8'(SETTLE_CYC + 1)) begin
            state_q <= KPMS_STORE;
          end else begin
            settle_q <= settle_q + 1'b1;
          end
        end
        KPMS_STORE: begin
          settle_q <= '0;
          if (col_q == 3'(COLS - 1)) begin
            state_q <= KPMS_IDLE;
          end else begin
            col_q   <= col_q + 1'b1;
            state_q <= KPMS_DRIVE;
          end
        end
        default: state_q <= KPMS_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int c = 0; c < COLS; c++) begin
        res_q[c] <= '0;
      end
    end else if (state_q == KPMS_STORE) begin
      res_q[col_q] <= row_s2_q;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_column_scan_out <= '0;
    end else if (busy) begin
      o_column_scan_out <= COLS'(1) << col_q;
    end else begin
      o_column_scan_out <= ctrl_q[CTL_COLSEL +: COLS];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status: set wins over clear
  logic [ST_W-1:0] ev, clr;

  assign ev  = {scan_done && by_act_q, dir_evt, mat_evt};
  assign clr = (wr_en && i_paddr == OFS_ICLR) ? i_pwdata[ST_W-1:0] : '0;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~clr) | ev;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |((stat_q & ~clr | ev) & ien_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path, captured in the setup cycle
  always_comb begin
    rdata_d = '0;
    hit_d   = 1'b1;
    case (i_paddr)
      OFS_CTRL: rdata_d[CTL_W-1:0] = ctrl_q;
      OFS_DBNC: rdata_d[7:0] = dbnc_q;
      OFS_ROWS: rdata_d[ROWS-1:0] = row_s2_q;
      OFS_DKEY: rdata_d[DKEYS-1:0] = dk_out_q;
      OFS_ENC:  rdata_d[15:0] = {enc_cnt[1], enc_cnt[0]};
      OFS_STAT: rdata_d = {23'h0, busy, 5'h0, stat_q};
      OFS_ICLR: rdata_d = '0;
      OFS_IEN:  rdata_d[ST_W-1:0] = ien_q;
      default: begin
        if (i_paddr >= OFS_RES0 && i_paddr < OFS_RES0 + 8'(4 * COLS)
            && i_paddr[1:0] == 2'h0) begin
          rdata_d[ROWS-1:0] = res_q[3'(i_paddr[4:2])];
        end else begin
          hit_d = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_prdata  <= i_pwrite ? 32'h0 : rdata_d;
      o_pslverr <= !hit_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  localparam int SCAN_MAX = 130 * 6 + 2;

  AST_COL_MANUAL: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !busy ##1 $stable(ctrl_q) |-> o_column_scan_out == ctrl_q[CTL_COLSEL +: COLS])
    else $error("manual column output differs from select bits");
  AST_COL_AUTO: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    busy |=> $onehot(o_column_scan_out))
    else $error("auto scan drives no single column");
  AST_SCAN_ENDS: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    $rose(busy) |-> ##[1:SCAN_MAX] scan_done)
    else $error("auto scan did not complete");
  AST_ACT_IRQ: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    scan_done && by_act_q |=> stat_q[ST_SCAN])
    else $error("activity scan completion not flagged");
  AST_SW_QUIET: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    scan_done && !by_act_q && !stat_q[ST_SCAN] |=> !stat_q[ST_SCAN])
    else $error("software scan raised an interrupt");
  AST_DBNC_RST: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    changed |=> dbnc_cnt_q == 9'h000)
    else $error("debounce count not restarted");
  AST_IGNORE: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    ctrl_q[CTL_IGNMULT] && (|mat_stb_q) && !stat_q[ST_MAT] |=> !stat_q[ST_MAT])
    else $error("second press reported under ignore policy");
  AST_MAT_FLAG: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    mat_evt |=> stat_q[ST_MAT] ##1 (o_irq || !ien_q[ST_MAT]))
    else $error("debounced activity not flagged");
  AST_DIR_OFF: assert property (@(posedge i_mclk) disable iff (!i_rstn)
    !ctrl_q[CTL_DIR_EN] |-> dk_mon == '0)
    else $error("direct keys seen while disabled");

  COV_ACT_SCAN: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    scan_done && by_act_q);
  COV_SW_SCAN: cover property (@(posedge i_mclk) disable iff (!i_rstn)
    scan_done && !by_act_q);
  COV_DIR_EVT: cover property (@(posedge i_mclk) disable iff (!i_rstn) dir_evt);
  COV_IRQ: cover property (@(posedge i_mclk) disable iff (!i_rstn) $rose(o_irq));
endmodule

// >>> kpms_keys.sv
module kpms_keys
  import kpms_pkg::*;
(
  // Column drive from the scanner
  input  wire logic [COLS-1:0]      i_column_scan_out,
  // Pressed keys, bit c*ROWS+r, and direct key levels
  input  wire logic [COLS*ROWS-1:0] i_key_map,
  input  wire logic [DKEYS-1:0]     i_direct_set,
  // Returns to the scanner
  output logic      [ROWS-1:0]      o_matrix_row_in,
  output logic      [DKEYS-1:0]     o_direct_key_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // A pressed key shorts its column to its row; rows are pulled down
  always_comb begin
    o_matrix_row_in = '0;
    for (int c = 0; c < COLS; c++) begin
      if (i_column_scan_out[c]) begin
        o_matrix_row_in |= i_key_map[c*ROWS +: ROWS];
      end
    end
  end
  assign o_direct_key_in = i_direct_set;
endmodule

// >>> keypad_matrix_scanner_test.sv
module keypad_matrix_scanner_test
  import kpms_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] C_MAT = 32'h1 << CTL_MAT_EN;
  localparam logic [31:0] C_DIR = 32'h1 << CTL_DIR_EN;
  localparam logic [31:0] C_IGN = 32'h1 << CTL_IGNMULT;
  localparam logic [31:0] C_AUT = 32'h1 << CTL_AUTO_EN;
  localparam logic [31:0] C_ACT = 32'h1 << CTL_ACT_EN;
  localparam logic [31:0] C_ENA = 32'h1 << CTL_ENCA_EN;
  localparam logic [31:0] C_ENB = 32'h1 << CTL_ENCB_EN;
  localparam logic [31:0] C_GO  = 32'h1 << CTL_START;
  logic                   mclk;
  logic                   rstn;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [7:0]             paddr;
  logic [31:0]            pwdata;
  logic                   pready;
  logic                   pslverr;
  logic [31:0]            prdata;
  logic [ROWS-1:0]        rows;
  logic [DKEYS-1:0]       dkin;
  logic [DKEYS-1:0]       dset;
  logic [COLS-1:0]        cols;
  logic                   irq;
  logic [COLS*ROWS-1:0]   keys;
  logic [31:0]            rd;
  logic                   err;
  logic [7:0]             fwd;
  int                     failures;
  int                     samples_checked;

  always #4 mclk = ~mclk;

  kpms_top u_dut (
    .i_mclk(mclk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .i_matrix_row_in(rows), .i_direct_key_in(dkin),
    .o_column_scan_out(cols), .o_irq(irq)
  );
  kpms_keys u_keys (
    .i_column_scan_out(cols), .i_key_map(keys), .i_direct_set(dset),
    .o_matrix_row_in(rows), .o_direct_key_in(dkin)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Entered just after a rising edge; leaves one idle edge so calls chain safely
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    // No wait-state count is assumed; only the watchdog ends a stuck access
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic poll(input int b, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      xfer(1'b0, OFS_STAT, 32'h0);
      n++;
    end while (rd[b] !== v && n < lim);
  endtask

  task automatic results();
    for (int c = 0; c < COLS; c++) begin
      rdchk(OFS_RES0 + 8'(4*c), 32'(keys[c*ROWS +: ROWS]));
    end
  endtask

  // One full quadrature cycle on the pair at bit sh, forward or back
  task automatic steps(input int sh, input bit up);
    logic [1:0] seq [4];
    seq = '{2'b01, 2'b11, 2'b10, 2'b00};
    for (int i = 0; i < 4; i++) begin
      dset[sh +: 2] <= up ? seq[i] : seq[(6-i)%4];
      idle(20);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    keys = '0;
    dset = 8'h00;
    failures = 0;
    samples_checked = 0;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rdchk(OFS_CTRL, 32'h0);
    rdchk(OFS_DBNC, 32'h0000_000A);
    rdchk(OFS_STAT, 32'h0);
    rdchk(OFS_IEN, 32'h0);
    check(32'(cols), 32'h0);
    xfer(1'b0, 8'h40, 32'h0);
    check({rd[30:0], err}, 32'h1);
    check(32'(pready), 32'h1);
    xfer(1'b1, OFS_ENC, 32'hFFFF);
    rdchk(OFS_ENC, 32'h0);
    // Manual scan: walk a single column through every position
    keys <= 48'h0001_0020_0080;
    for (int c = 0; c < COLS; c++) begin
      xfer(1'b1, OFS_CTRL, 32'h1 << c);
      idle(4);
      check(32'(cols), 32'h1 << c);
      rdchk(OFS_ROWS, 32'(keys[c*ROWS +: ROWS]));
    end
    // Debounce: bounce faster than two ticks, then settle
    keys <= '0;
    xfer(1'b1, OFS_DBNC, 32'h1);
    xfer(1'b1, OFS_CTRL, C_MAT | 32'h3F);
    for (int i = 0; i < 6; i++) begin
      keys <= (i % 2) ? 48'h1 : 48'h2;
      idle(100);
    end
    rdchk(OFS_STAT, 32'h0);
    poll(ST_MAT, 1'b1, 200);
    check(32'(rd[2:0]), 32'h1);
    check(32'(irq), 32'h0);
    xfer(1'b1, OFS_IEN, 32'h7);
    idle(2);
    check(32'(irq), 32'h1);
    xfer(1'b1, OFS_ICLR, 32'h7);
    idle(2);
    check(32'(irq), 32'h0);
    // Second key while the first is held gives nothing under the policy
    xfer(1'b1, OFS_CTRL, C_MAT | C_IGN | 32'h3F);
    keys <= keys | 48'h4;
    idle(600);
    rdchk(OFS_STAT, 32'h0);
    keys <= '0;
    idle(600);
    keys <= 48'h8;
    poll(ST_MAT, 1'b1, 300);
    check(32'(rd[0]), 32'h1);
    xfer(1'b1, OFS_ICLR, 32'h7);
    // Software-started scan
    keys <= 48'h0001_0020_0080;
    xfer(1'b1, OFS_CTRL, C_AUT | 32'h2A);
    xfer(1'b1, OFS_CTRL, C_AUT | C_GO | 32'h2A);
    for (int c = 0; c < COLS; c++) begin
      for (int n = 0; n < 300 && cols !== 6'(1 << c); n++) @(posedge mclk);
      check(32'(cols), 32'h1 << c);
    end
    poll(ST_BUSY, 1'b0, 300);
    check(32'(rd[ST_BUSY]), 32'h0);
    results();
    idle(2);
    check(32'(cols), 32'h2A);
    rdchk(OFS_STAT, 32'h0);
    check(32'(irq), 32'h0);
    // Activity-started scan
    keys <= 48'h0000_8000_0400;
    xfer(1'b1, OFS_CTRL, C_MAT | C_AUT | C_ACT | 32'h3F);
    poll(ST_SCAN, 1'b1, 800);
    check(32'(rd[ST_SCAN]), 32'h1);
    idle(2);
    check(32'(irq), 32'h1);
    results();
    xfer(1'b1, OFS_ICLR, 32'h7);
    // Direct keys beside a held matrix key
    xfer(1'b1, OFS_CTRL, C_DIR | C_MAT | 32'h3F);
    dset <= 8'hC0;
    poll(ST_DIR, 1'b1, 300);
    check(32'(rd[ST_DIR]), 32'h1);
    rdchk(OFS_DKEY, 32'h0000_00C0);
    // Encoders
    dset <= 8'h00;
    xfer(1'b1, OFS_CTRL, C_DIR | C_ENA);
    idle(20);
    rdchk(OFS_ENC, 32'h0);
    steps(0, 1'b1);
    steps(2, 1'b1);
    xfer(1'b0, OFS_ENC, 32'h0);
    fwd = rd[7:0];
    check(32'(fwd), 32'h04);
    check(32'(rd[15:8]), 32'h0);
    steps(0, 1'b0);
    rdchk(OFS_ENC, 32'h0);
    xfer(1'b1, OFS_CTRL, C_DIR | C_ENA | C_ENB);
    steps(2, 1'b1);
    xfer(1'b0, OFS_ENC, 32'h0);
    check(32'(rd[15:8]), 32'(fwd));
    give_verdict();
  end

  // The tests need under a tenth of this span
  initial begin
    repeat (60000) @(posedge mclk);
    failures++;
    give_verdict();
  end
endmodule
